/* logic/pfo_deadtime.sv */
// Purpose: complementary pair outputs with per-edge dead-time unit choice
// Assumes: raw pair waveforms come from the same clock
// Notes:   both pins of a pair stay off while dead time runs
`timescale 1ns/1ps
module pfo_deadtime #(
   parameter int PAIRS = 4
) (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               reset,
   // waveform and mode
   input  wire logic [PAIRS-1:0]   raw,
   input  wire logic [PAIRS-1:0]   independent,
   input  wire logic [2*PAIRS-1:0] edge_src,
   // dead-time units
   input  wire logic [5:0]         unit_a_count,
   input  wire logic [1:0]         unit_a_scale,
   input  wire logic [5:0]         unit_b_count,
   input  wire logic [1:0]         unit_b_scale,
   // pair outputs
   output logic [PAIRS-1:0]        pin_hi,
   output logic [PAIRS-1:0]        pin_lo
);
   import pfo_pkg::*;

   logic [PRE_WIDTH-1:0] pre_ff;
   logic [PRE_WIDTH-1:0] nxt_pre;
   logic                 tick_a;
   logic                 tick_b;

   // ----------------------------------------------------------------
   // prescaler, one-cycle ticks per unit
   // ----------------------------------------------------------------
   always_comb begin
      nxt_pre = pre_ff + 5'h01;
      tick_a  = &(pre_ff | ~(PRE_FULL >> (PRE_TOP - unit_a_scale)));
      tick_b  = &(pre_ff | ~(PRE_FULL >> (PRE_TOP - unit_b_scale)));
   end

   always_ff @(posedge clock) begin
      if (reset)
         pre_ff <= 5'h00;
      else
         pre_ff <= nxt_pre;
   end

   // ----------------------------------------------------------------
   // per pair edge timing
   // ----------------------------------------------------------------
   for (genvar p = 0; p < PAIRS; p++) begin : g_pair
      logic       prev_ff;
      logic       use_b_ff;
      logic [5:0] cnt_ff;
      logic       hi_ff;
      logic       lo_ff;
      logic       nxt_use_b;
      logic [5:0] nxt_cnt;
      logic       nxt_hi;
      logic       nxt_lo;

      always_comb begin
         nxt_use_b = use_b_ff;
         nxt_cnt   = cnt_ff;
         if (independent[p]) begin
            nxt_cnt = 6'h00;
         end else if (raw[p] != prev_ff) begin
            nxt_use_b = raw[p] ? edge_src[2*p+1] : edge_src[2*p];
            nxt_cnt   = nxt_use_b ? unit_b_count : unit_a_count;
         end else if (cnt_ff != 6'h00 && (use_b_ff ? tick_b : tick_a)) begin
            nxt_cnt = cnt_ff - 6'h01;
         end
         if (independent[p]) begin
            nxt_hi = raw[p];
            nxt_lo = raw[p];
         end else begin
            nxt_hi = raw[p] & (nxt_cnt == 6'h00);
            nxt_lo = ~raw[p] & (nxt_cnt == 6'h00);
         end
      end

      always_ff @(posedge clock) begin
         if (reset) begin
            prev_ff  <= 1'b0;
            use_b_ff <= 1'b0;
            cnt_ff   <= 6'h00;
            hi_ff    <= 1'b0;
            lo_ff    <= 1'b0;
         end else begin
            prev_ff  <= raw[p];
            use_b_ff <= nxt_use_b;
            cnt_ff   <= nxt_cnt;
            hi_ff    <= nxt_hi;
            lo_ff    <= nxt_lo;
         end
      end

      assign pin_hi[p] = hi_ff;
      assign pin_lo[p] = lo_ff;
   end

endmodule : pfo_deadtime

/* logic/pfo_fault.sv */
// Purpose: one fault input: synchroniser and latched / cycle-by-cycle tracking
// Assumes: fault pin is active low and asynchronous
// Notes:   latched fault leaves on a clear request while the pin is inactive
`timescale 1ns/1ps
module pfo_fault (
   // clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // pin and control
   input  wire logic fault_n,
   input  wire logic limit_mode,
   input  wire logic clear_req,
   input  wire logic period_start,
   // state
   output logic      active
);
   import pfo_pkg::*;

   logic             meta_ff;
   logic             sync_ff;
   pfo_fault_state_t state_ff;
   pfo_fault_state_t nxt_state;
   logic             asserted;

   // ----------------------------------------------------------------
   // two-stage synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
      end else begin
         meta_ff <= fault_n;
         sync_ff <= meta_ff;
      end
   end

   assign asserted = ~sync_ff;

   // ----------------------------------------------------------------
   // tracker
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         FS_IDLE: begin
            if (asserted)
               nxt_state = limit_mode ? FS_CYCLE : FS_LATCH;
         end
         FS_LATCH: begin
            if (clear_req && !asserted)
               nxt_state = FS_IDLE;
         end
         FS_CYCLE: begin
            if (!asserted && period_start)
               nxt_state = FS_IDLE;
         end
         default: nxt_state = FS_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset)
         state_ff <= FS_IDLE;
      else
         state_ff <= nxt_state;
   end

   assign active = (state_ff != FS_IDLE);

endmodule : pfo_fault

/* logic/pfo_pkg.sv */
// Purpose: shared constants and types of the pwm fault/override block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   16-bit registers sit in the low half of each word
package pfo_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_DT_SEL   = 8'h00;
   localparam logic [7:0] OFS_FAULT_A  = 8'h04;
   localparam logic [7:0] OFS_FAULT_B  = 8'h08;
   localparam logic [7:0] OFS_OVERRIDE = 8'h0C;
   localparam logic [7:0] OFS_DUTY1    = 8'h10;
   localparam logic [7:0] OFS_DUTY2    = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_ZERO     = 16'h0000;
   localparam logic [15:0] RST_OVERRIDE = 16'hFF00;
   localparam logic [15:0] MASK_DT_SEL  = 16'h00FF;
   localparam logic [15:0] MASK_FAULT   = 16'hFF8F;
   localparam logic [15:0] MASK_FULL    = 16'hFFFF;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int FLT_EN_LSB   = 0;
   localparam int FLT_MODE_BIT = 7;
   localparam int FLT_PIN_LSB  = 8;
   localparam int OVR_PIN_LSB  = 0;
   localparam int OVR_SRC_LSB  = 8;
   localparam int STS_FAULT_A  = 0;
   localparam int STS_FAULT_B  = 1;

   // ----------------------------------------------------------------
   // dead-time prescaler: clock/4 up to clock/32
   // ----------------------------------------------------------------
   localparam int          PRE_WIDTH = 5;
   localparam logic [4:0]  PRE_FULL  = 5'h1F;
   localparam logic [1:0]  PRE_TOP   = 2'h3;

   // ----------------------------------------------------------------
   // fault tracker states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FS_IDLE  = 3'b001,
      FS_LATCH = 3'b010,
      FS_CYCLE = 3'b100
   } pfo_fault_state_t;

endpackage : pfo_pkg

/* logic/pfo_top.sv */
// Purpose: pwm fault handling, output override, dead-time select, duty 1/2
// Assumes: time base, pair mode and dead-time unit settings arrive as inputs
// Notes:   registers over classic wishbone, one word each
//
// Notes on behaviour
// - select bit one picks unit B
// - dead-time select upper byte reads zero
// - fault A forces pins to programmed states
// - fault A mode: cycle limit or latched
// - per-pair enable for fault A
// - fault B own states and mode
// - per-pair enable for fault B
// - fault registers bits six-four read zero
// - source select: pwm or manual, resets one
// - manual level drives pin, resets zero
// - duty one, 16-bit, resets zero
// - duty two, 16-bit, resets zero
// - fault and select fields reset zero
// - override changes follow period start optionally
// - dead-time units count with prescaled ticks
// - pair complementary with dead time, or independent
`timescale 1ns/1ps
module pfo_top (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // time base and generators 3/4
   input  wire logic [14:0] tb_count,
   input  wire logic        period_start,
   input  wire logic [1:0]  pair34_raw,
   // pair mode and sync
   input  wire logic [3:0]  pair_independent_select,
   input  wire logic        override_sync_select,
   // dead-time units
   input  wire logic [5:0]  deadtime_unit_a_count,
   input  wire logic [1:0]  deadtime_unit_a_scale,
   input  wire logic [5:0]  deadtime_unit_b_count,
   input  wire logic [1:0]  deadtime_unit_b_scale,
   // fault pins
   input  wire logic        fault_a_n,
   input  wire logic        fault_b_n,
   // pwm pins
   output logic [7:0]       pwm_pin
);
   import pfo_pkg::*;

   logic [15:0] dt_sel_ff;
   logic [15:0] fault_a_ff;
   logic [15:0] fault_b_ff;
   logic [15:0] ovr_ff;
   logic [15:0] duty1_ff;
   logic [15:0] duty2_ff;
   logic [15:0] eff_ovr_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic [7:0]  pin_ff;
   logic [15:0] nxt_dt_sel;
   logic [15:0] nxt_fault_a;
   logic [15:0] nxt_fault_b;
   logic [15:0] nxt_ovr;
   logic [15:0] nxt_duty1;
   logic [15:0] nxt_duty2;
   logic [15:0] nxt_eff_ovr;
   logic        nxt_ack;
   logic [31:0] nxt_rdata;
   logic [7:0]  nxt_pin;
   logic        wr_now;
   logic        clr_a;
   logic        clr_b;
   logic        flt_a_act;
   logic        flt_b_act;
   logic [3:0]  raw;
   logic [3:0]  dt_hi;
   logic [3:0]  dt_lo;
   logic [7:0]  pwm_base;

   // ----------------------------------------------------------------
   // byte-lane merge with writable mask
   // ----------------------------------------------------------------
   function automatic logic [15:0] lane_wr(input logic [15:0] cur,
                                           input logic [15:0] wdat,
                                           input logic [1:0]  sel,
                                           input logic [15:0] mask);
      logic [15:0] merged;
      merged[7:0]  = sel[0] ? wdat[7:0] : cur[7:0];
      merged[15:8] = sel[1] ? wdat[15:8] : cur[15:8];
      return merged & mask;
   endfunction : lane_wr

   // ----------------------------------------------------------------
   // bus handshake and register writes
   // ----------------------------------------------------------------
   assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
   assign clr_a  = wr_now && (wb_adr_i == OFS_FAULT_A);
   assign clr_b  = wr_now && (wb_adr_i == OFS_FAULT_B);

   always_comb begin
      nxt_ack     = wb_cyc_i & wb_stb_i & ~ack_ff;
      nxt_dt_sel  = dt_sel_ff;
      nxt_fault_a = fault_a_ff;
      nxt_fault_b = fault_b_ff;
      nxt_ovr     = ovr_ff;
      nxt_duty1   = duty1_ff;
      nxt_duty2   = duty2_ff;
      if (wr_now) begin
         case (wb_adr_i)
            OFS_DT_SEL: begin
               nxt_dt_sel = lane_wr(dt_sel_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                                    MASK_DT_SEL);
            end
            OFS_FAULT_A: begin
               nxt_fault_a = lane_wr(fault_a_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                                     MASK_FAULT);
            end
            OFS_FAULT_B: begin
               nxt_fault_b = lane_wr(fault_b_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                                     MASK_FAULT);
            end
            OFS_OVERRIDE: begin
               nxt_ovr = lane_wr(ovr_ff, wb_dat_i[15:0], wb_sel_i[1:0], MASK_FULL);
            end
            OFS_DUTY1: begin
               nxt_duty1 = lane_wr(duty1_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                                   MASK_FULL);
            end
            OFS_DUTY2: begin
               nxt_duty2 = lane_wr(duty2_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                                   MASK_FULL);
            end
            default: begin
               nxt_duty2 = duty2_ff;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read data, captured with ack
   // ----------------------------------------------------------------
   always_comb begin
      nxt_rdata = rdata_ff;
      if (nxt_ack) begin
         case (wb_adr_i)
            OFS_DT_SEL:   nxt_rdata = {16'h0000, dt_sel_ff};
            OFS_FAULT_A:  nxt_rdata = {16'h0000, fault_a_ff};
            OFS_FAULT_B:  nxt_rdata = {16'h0000, fault_b_ff};
            OFS_OVERRIDE: nxt_rdata = {16'h0000, ovr_ff};
            OFS_DUTY1:    nxt_rdata = {16'h0000, duty1_ff};
            OFS_DUTY2:    nxt_rdata = {16'h0000, duty2_ff};
            OFS_STATUS:   nxt_rdata = {30'h00000000, flt_b_act, flt_a_act};
            default:      nxt_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ack_ff     <= 1'b0;
         rdata_ff   <= 32'h00000000;
         dt_sel_ff  <= RST_ZERO;
         fault_a_ff <= RST_ZERO;
         fault_b_ff <= RST_ZERO;
         ovr_ff     <= RST_OVERRIDE;
         duty1_ff   <= RST_ZERO;
         duty2_ff   <= RST_ZERO;
      end else begin
         ack_ff     <= nxt_ack;
         rdata_ff   <= nxt_rdata;
         dt_sel_ff  <= nxt_dt_sel;
         fault_a_ff <= nxt_fault_a;
         fault_b_ff <= nxt_fault_b;
         ovr_ff     <= nxt_ovr;
         duty1_ff   <= nxt_duty1;
         duty2_ff   <= nxt_duty2;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;

   // ----------------------------------------------------------------
   // fault inputs
   // ----------------------------------------------------------------
   pfo_fault u_fault_a (
      .clock        (clock),
      .reset        (reset),
      .fault_n      (fault_a_n),
      .limit_mode   (fault_a_ff[FLT_MODE_BIT]),
      .clear_req    (clr_a),
      .period_start (period_start),
      .active       (flt_a_act)
   );

   pfo_fault u_fault_b (
      .clock        (clock),
      .reset        (reset),
      .fault_n      (fault_b_n),
      .limit_mode   (fault_b_ff[FLT_MODE_BIT]),
      .clear_req    (clr_b),
      .period_start (period_start),
      .active       (flt_b_act)
   );

   // ----------------------------------------------------------------
   // raw waveforms and dead time
   // ----------------------------------------------------------------
   assign raw = {pair34_raw, ({1'b0, tb_count} < duty2_ff), ({1'b0, tb_count} < duty1_ff)};

   pfo_deadtime #(
      .PAIRS (4)
   ) u_deadtime (
      .clock        (clock),
      .reset        (reset),
      .raw          (raw),
      .independent  (pair_independent_select),
      .edge_src     (dt_sel_ff[7:0]),
      .unit_a_count (deadtime_unit_a_count),
      .unit_a_scale (deadtime_unit_a_scale),
      .unit_b_count (deadtime_unit_b_count),
      .unit_b_scale (deadtime_unit_b_scale),
      .pin_hi       (dt_hi),
      .pin_lo       (dt_lo)
   );

   assign pwm_base = {dt_hi[3], dt_lo[3], dt_hi[2], dt_lo[2],
                      dt_hi[1], dt_lo[1], dt_hi[0], dt_lo[0]};

   // ----------------------------------------------------------------
   // override copy and pin priority
   // ----------------------------------------------------------------
   always_comb begin
      nxt_eff_ovr = eff_ovr_ff;
      if (!override_sync_select || period_start)
         nxt_eff_ovr = ovr_ff;
      for (int i = 0; i < 8; i++) begin
         if (eff_ovr_ff[OVR_SRC_LSB + i])
            nxt_pin[i] = pwm_base[i];
         else
            nxt_pin[i] = eff_ovr_ff[OVR_PIN_LSB + i];
         if (flt_b_act && fault_b_ff[FLT_EN_LSB + i/2])
            nxt_pin[i] = fault_b_ff[FLT_PIN_LSB + i];
         if (flt_a_act && fault_a_ff[FLT_EN_LSB + i/2])
            nxt_pin[i] = fault_a_ff[FLT_PIN_LSB + i];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         eff_ovr_ff <= RST_OVERRIDE;
         pin_ff     <= 8'h00;
      end else begin
         eff_ovr_ff <= nxt_eff_ovr;
         pin_ff     <= nxt_pin;
      end
   end

   assign pwm_pin = pin_ff;

endmodule : pfo_top

/* tb/pfo_stage.sv */
// Purpose: power stage beside the pwm pins, reports over-current faults
// Assumes: fault lines are pulled up and pulled low on a trip
// Notes:   trips are commanded by the bench
`timescale 1ns/1ps
module pfo_stage (
   // trip commands
   input  wire logic trip_a,
   input  wire logic trip_b,
   // fault lines, active low
   output logic      fault_a_n,
   output logic      fault_b_n
);
   assign fault_a_n = !trip_a;
   assign fault_b_n = !trip_b;
endmodule : pfo_stage

/* tb/pfo_sva.sv */
// Purpose: port checks on the bus handshake and read-back of pfo_top
// Assumes: classic wishbone slave with one-cycle ack
// Notes:   attached by bind below
`timescale 1ns/1ps
module pfo_sva
   import pfo_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // fault pin
   input wire logic        fault_a_n
);
   logic rd_ack;
   assign rd_ack = wb_ack_o && !wb_we_i;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // ------------------------------------------------------------
   // handshake and read data
   // ------------------------------------------------------------
   ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack while bus idle");
   dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read half not zero");
   dt_upper_a: assert property (rd_ack && wb_adr_i == OFS_DT_SEL |-> wb_dat_o[15:8] == 8'h00)
      else $error("dead-time select upper byte not zero");
   flt_hole_a: assert property (
      rd_ack && (wb_adr_i == OFS_FAULT_A || wb_adr_i == OFS_FAULT_B)
      |-> wb_dat_o[6:4] == 3'h0)
      else $error("fault register bits 6-4 not zero");
   unmapped_a: assert property (rd_ack && wb_adr_i > OFS_STATUS |-> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   wr_cover: cover property (wb_ack_o && wb_we_i);
   rd_cover: cover property (rd_ack);
   flt_cover: cover property ($fell(fault_a_n));
endmodule : pfo_sva

bind pfo_top pfo_sva pfo_sva_i (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .fault_a_n(fault_a_n));

/* tb/tb_top.sv */
// Purpose: self-checking bench of pfo_top
// Assumes: 200 MHz clock, synchronous reset
// Notes:   one task per scenario
`timescale 1ns/1ps
module tb_top;
   import pfo_pkg::*;
   logic        clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        period_start, override_sync_select, fault_a_n, fault_b_n, trip_a, trip_b;
   logic [7:0]  wb_adr_i, pwm_pin;
   logic [3:0]  wb_sel_i, pair_independent_select;
   logic [31:0] wb_dat_i, wb_dat_o, rdat;
   logic [14:0] tb_count;
   logic [1:0]  pair34_raw;
   int          fail_count = 0;
   int          tests_run = 0;
   int          cycles = 0;
   localparam logic [7:0]  OFS_LIST [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   localparam logic [15:0] RST_LIST [6] = '{16'h0000, 16'h0000, 16'h0000, 16'hFF00,
                                           16'h0000, 16'h0000};
   localparam logic [15:0] WR_LIST  [6] = '{16'h00FF, 16'hFF8F, 16'hFF8F, 16'hFFFF,
                                           16'hFFFF, 16'hFFFF};
   pfo_top pfo_top_i (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tb_count(tb_count),
      .period_start(period_start), .pair34_raw(pair34_raw),
      .pair_independent_select(pair_independent_select),
      .override_sync_select(override_sync_select),
      .deadtime_unit_a_count(6'h01), .deadtime_unit_a_scale(2'h0),
      .deadtime_unit_b_count(6'h14), .deadtime_unit_b_scale(2'h3),
      .fault_a_n(fault_a_n), .fault_b_n(fault_b_n), .pwm_pin(pwm_pin));
   pfo_stage pfo_stage_i (.trip_a(trip_a), .trip_b(trip_b), .fault_a_n(fault_a_n),
      .fault_b_n(fault_b_n));
   // ------------------------------------------------------------
   // clock, timeout and helpers
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("checks run %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] dat);
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h3;
      wb_dat_i <= {16'h0000, dat};
      do @(posedge clock); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : wait_cyc
   task automatic pulse_period;
      @(posedge clock);
      period_start <= 1'b1;
      @(posedge clock);
      period_start <= 1'b0;
   endtask : pulse_period
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic s_regs;
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, OFS_LIST[i], 16'h0000);
         check(rdat, {16'h0000, RST_LIST[i]});
         bus(1'b1, OFS_LIST[i], 16'hFFFF);
         bus(1'b0, OFS_LIST[i], 16'h0000);
         check(rdat, {16'h0000, WR_LIST[i]});
         bus(1'b1, OFS_LIST[i], RST_LIST[i]);
      end
      bus(1'b1, 8'h1C, 16'hFFFF);
      bus(1'b0, 8'h1C, 16'h0000);
   endtask : s_regs
   task automatic s_manual;
      bus(1'b1, OFS_OVERRIDE, 16'h00A5);
      wait_cyc(3);
      check(32'(pwm_pin), 32'h000000A5);
      bus(1'b1, OFS_OVERRIDE, 16'h005A);
      wait_cyc(3);
      check(32'(pwm_pin), 32'h0000005A);
      override_sync_select <= 1'b1;
      bus(1'b1, OFS_OVERRIDE, 16'h000F);
      wait_cyc(10);
      check(32'(pwm_pin), 32'h0000005A);
      pulse_period();
      wait_cyc(3);
      check(32'(pwm_pin), 32'h0000000F);
      override_sync_select <= 1'b0;
   endtask : s_manual
   task automatic s_deadtime;
      bus(1'b1, OFS_DUTY1, 16'h0010);
      bus(1'b1, OFS_DT_SEL, 16'h0002);
      bus(1'b1, OFS_OVERRIDE, 16'h0300);
      tb_count <= 15'h0020;
      wait_cyc(700);
      check(32'(pwm_pin[1:0]), 32'h1);
      tb_count <= 15'h0000;
      wait_cyc(50);
      check(32'(pwm_pin[1:0]), 32'h0);
      wait_cyc(540);
      check(32'(pwm_pin[1:0]), 32'h0);
      wait_cyc(110);
      check(32'(pwm_pin[1:0]), 32'h2);
      tb_count <= 15'h0020;
      wait_cyc(50);
      check(32'(pwm_pin[1:0]), 32'h1);
      bus(1'b1, OFS_DT_SEL, 16'h0000);
      tb_count <= 15'h0000;
      wait_cyc(50);
      check(32'(pwm_pin[1:0]), 32'h2);
      pair_independent_select <= 4'h1;
      wait_cyc(10);
      check(32'(pwm_pin[1:0]), 32'h3);
      pair_independent_select <= 4'h0;
      bus(1'b1, OFS_OVERRIDE, 16'hF000);
      pair34_raw <= 2'h1;
      wait_cyc(50);
      check(32'(pwm_pin[7:4]), 32'h6);
   endtask : s_deadtime
   task automatic s_faults;
      bus(1'b1, OFS_OVERRIDE, 16'h00FF);
      bus(1'b1, OFS_FAULT_A, 16'hC305);
      trip_a <= 1'b1;
      wait_cyc(8);
      check(32'(pwm_pin), 32'h000000CF);
      bus(1'b0, OFS_STATUS, 16'h0000);
      check(rdat, 32'h00000001);
      bus(1'b1, OFS_FAULT_A, 16'hC305);
      wait_cyc(4);
      check(32'(pwm_pin), 32'h000000CF);
      trip_a <= 1'b0;
      wait_cyc(8);
      check(32'(pwm_pin), 32'h000000CF);
      bus(1'b1, OFS_FAULT_A, 16'hC305);
      wait_cyc(6);
      check(32'(pwm_pin), 32'h000000FF);
      bus(1'b1, OFS_FAULT_B, 16'h0082);
      trip_b <= 1'b1;
      wait_cyc(8);
      check(32'(pwm_pin), 32'h000000F3);
      pulse_period();
      wait_cyc(4);
      check(32'(pwm_pin), 32'h000000F3);
      trip_b <= 1'b0;
      wait_cyc(8);
      check(32'(pwm_pin), 32'h000000F3);
      pulse_period();
      wait_cyc(4);
      check(32'(pwm_pin), 32'h000000FF);
   endtask : s_faults
   initial begin
      reset = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      tb_count = 15'h0000;
      period_start = 1'b0;
      pair34_raw = 2'h0;
      pair_independent_select = 4'h0;
      override_sync_select = 1'b0;
      trip_a = 1'b0;
      trip_b = 1'b0;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      s_regs();
      s_manual();
      s_deadtime();
      s_faults();
      stop_test();
   end
endmodule : tb_top
